/* hw/scfg_regs.vh */
`ifndef SCFG_REGS_VH
`define SCFG_REGS_VH

// Register addresses
`define SCFG_A_DEV_CTRL  8'h02
`define SCFG_A_DEV_CFG1  8'h03
`define SCFG_A_GLOB_CFG  8'h05
`define SCFG_A_RATIO3    8'h06
`define SCFG_A_RATIO0    8'h09
`define SCFG_A_FUNC_CFG1 8'h16
`define SCFG_A_FUNC_CFG2 8'h17

// Device control fields
`define SCFG_B_UNLOCK    7
`define SCFG_B_AUX_DIS   1
`define SCFG_B_CLK_DIS   0

// Device configuration 1 fields
`define SCFG_F_RMOD      7:5
`define SCFG_F_AUX_SRC   2:1
`define SCFG_B_PORT_EN1  0

// Global configuration fields
`define SCFG_B_FREEZE    3
`define SCFG_B_PORT_EN2  0

// Function configuration fields
`define SCFG_B_LOCK_STY  6
`define SCFG_F_REF_DIV   4:3
`define SCFG_B_OUT_UNL   4

// Writable bit masks
`define SCFG_M_DEV_CTRL  8'h03
`define SCFG_M_DEV_CFG1  8'hE7
`define SCFG_M_GLOB_CFG  8'h09
`define SCFG_M_FUNC_CFG1 8'h58
`define SCFG_M_FUNC_CFG2 8'h10

// Reset values
`define SCFG_RST_BYTE    8'h00
`define SCFG_RST_RATIO   32'h0000_0000

// Aux source codes
`define SCFG_AUX_REF     2'h0
`define SCFG_AUX_RSVD    2'h1
`define SCFG_AUX_CLK     2'h2
`define SCFG_AUX_LOCK    2'h3

// Reference divider codes and counts
`define SCFG_DIV4        2'h0
`define SCFG_DIV2        2'h1
`define SCFG_DIV1        2'h2
`define SCFG_DIV_N4      3'h4
`define SCFG_DIV_N2      3'h2
`define SCFG_DIV_N1      3'h1
`define SCFG_DIV_NONE    3'h0

// Ratio format
`define SCFG_RATIO_INT   12
`define SCFG_RATIO_FRAC  20

`endif

/* hw/scfg_top.v */
// Operation
// RULE_01: Freeze set: writes to 02h-04h stored but not applied until cleared. The code has no 04h register and stages only 02h and 03h.
// RULE_02: Freeze clear: control and configuration writes take effect at once.
// RULE_03: Control port mode only when both port enable bits are one.
// RULE_04: Ratio bytes 06h..09h concatenate, lowest address most significant.
// RULE_05: Ratio is unsigned 12.20 fixed point, ratio times two to twenty.
// RULE_06: Lock pin style matters only when aux source select is 11.
// RULE_07: Style 0: aux push-pull, high when unlocked, low when locked.
// RULE_08: Style 1: aux open drain, low when unlocked, floating when locked.
// RULE_09: Reference divider codes 00,01,10 divide by 4,2,1; 11 reserved.
// RULE_10: Host picks divider code matching reference frequency range.
// RULE_11: Output-on-unlock 0: clock outputs forced low while unlocked.
// RULE_12: Output-on-unlock 1: clock outputs always run, even unlocked.
// RULE_13: Registers readable and writable over I2C, write only over SPI.
// RULE_14: Host keeps reserved bits at their default on every write.
// RULE_15: Unlock status bit reads 0 when locked, 1 when unlocked.
`timescale 1ns/1ps
`include "scfg_regs.vh"
`default_nettype none

module scfg_top #(
	parameter RATIO_W = 32
) (
	// Clock and reset
	input  wire               core_clk_in,
	input  wire               rst_n_in,
	// Register port from serial decoder
	input  wire               reg_wr_in,
	input  wire               reg_rd_in,
	input  wire [7:0]         reg_addr_in,
	input  wire [7:0]         reg_wdata_in,
	input  wire               spi_mode_in,
	output reg  [7:0]         reg_rdata_out,
	output reg                reg_rvalid_out,
	// Loop status and clocks
	input  wire               pll_locked_in,
	input  wire               pll_clk_in,
	input  wire               timing_reference_in,
	// Applied configuration
	output wire               ctrl_port_mode_out,
	output wire [RATIO_W-1:0] user_ratio_out,
	output wire [2:0]         rmod_select_out,
	output reg                ref_div_pulse_out,
	// Clock output pin
	output reg                clk_out_out,
	output reg                clk_out_oe_n_out,
	// Auxiliary output pin
	output reg                aux_out_out,
	output reg                aux_out_oe_n_out
);

	// Stored (staged) control and configuration
	reg [7:0] dev_ctrl_q;
	reg [7:0] dev_cfg1_q;
	// Applied copies of the frozen group
	reg [7:0] dev_ctrl_app_q;
	reg [7:0] dev_cfg1_app_q;
	// Registers outside the frozen group
	reg [7:0] glob_cfg_q;
	reg [7:0] func_cfg1_q;
	reg [7:0] func_cfg2_q;
	reg [7:0] ratio_q [0:3];
	// Reference divider state
	reg       ref_prev_q;
	reg [2:0] ref_cnt_q;
	reg [2:0] ref_cnt_d;
	reg       ref_pulse_d;
	reg [2:0] div_n;
	// Read data mux
	reg [7:0] rdata_d;

	wire       unlocked;
	wire       freeze;
	wire       ref_rise;
	wire [1:0] aux_src;
	wire       lock_style;
	wire       out_on_unl;

	// Divide count for a reference divider code
	function [2:0] scfg_div_count;
		input [1:0] code;
		begin
			case (code)
				`SCFG_DIV4: scfg_div_count = `SCFG_DIV_N4;
				`SCFG_DIV2: scfg_div_count = `SCFG_DIV_N2;
				`SCFG_DIV1: scfg_div_count = `SCFG_DIV_N1;
				default:    scfg_div_count = `SCFG_DIV_NONE;
			endcase
		end
	endfunction

	// Register write strobe for one address
	function scfg_hit;
		input       wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			scfg_hit = wr && (addr == target);
		end
	endfunction

	// Address falls inside the ratio bytes
	function scfg_is_ratio;
		input [7:0] addr;
		begin
			scfg_is_ratio = (addr >= `SCFG_A_RATIO3) &&
				(addr <= `SCFG_A_RATIO0);
		end
	endfunction

	// Ratio byte slot of an address, 06h maps to 0
	function [1:0] scfg_ratio_slot;
		input [7:0] addr;
		reg   [7:0] off;
		begin
			off             = addr - `SCFG_A_RATIO3;
			scfg_ratio_slot = off[1:0];
		end
	endfunction

	assign unlocked   = ~pll_locked_in;
	assign freeze     = glob_cfg_q[`SCFG_B_FREEZE];
	assign aux_src    = dev_cfg1_app_q[`SCFG_F_AUX_SRC];
	assign lock_style = func_cfg1_q[`SCFG_B_LOCK_STY];
	assign out_on_unl = func_cfg2_q[`SCFG_B_OUT_UNL];

	// Control port mode needs both enables
	assign ctrl_port_mode_out = dev_cfg1_app_q[`SCFG_B_PORT_EN1] &
		glob_cfg_q[`SCFG_B_PORT_EN2]; // see RULE_03
	assign rmod_select_out = dev_cfg1_app_q[`SCFG_F_RMOD];

	// Staged control/config writes, reserved bits kept at zero
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			dev_ctrl_q <= `SCFG_RST_BYTE;
			dev_cfg1_q <= `SCFG_RST_BYTE;
		end else begin
			if (scfg_hit(reg_wr_in, reg_addr_in, `SCFG_A_DEV_CTRL))
				dev_ctrl_q <= reg_wdata_in & `SCFG_M_DEV_CTRL;
			if (scfg_hit(reg_wr_in, reg_addr_in, `SCFG_A_DEV_CFG1))
				dev_cfg1_q <= reg_wdata_in & `SCFG_M_DEV_CFG1;
		end
	end

	// Applied copies follow staged values only while unfrozen
	// Staged copies keep taking writes, so a read shows what will
	// apply once freeze drops
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			dev_ctrl_app_q <= `SCFG_RST_BYTE;
			dev_cfg1_app_q <= `SCFG_RST_BYTE;
		end else if (!freeze) begin // see RULE_01
			dev_ctrl_app_q <= dev_ctrl_q; // see RULE_02
			dev_cfg1_app_q <= dev_cfg1_q; // see RULE_02
		end
	end

	// Global and function configuration, always applied
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			glob_cfg_q  <= `SCFG_RST_BYTE;
			func_cfg1_q <= `SCFG_RST_BYTE;
			func_cfg2_q <= `SCFG_RST_BYTE;
		end else begin
			if (scfg_hit(reg_wr_in, reg_addr_in, `SCFG_A_GLOB_CFG))
				glob_cfg_q <= reg_wdata_in & `SCFG_M_GLOB_CFG;
			if (scfg_hit(reg_wr_in, reg_addr_in, `SCFG_A_FUNC_CFG1))
				func_cfg1_q <= reg_wdata_in & `SCFG_M_FUNC_CFG1;
			if (scfg_hit(reg_wr_in, reg_addr_in, `SCFG_A_FUNC_CFG2))
				func_cfg2_q <= reg_wdata_in & `SCFG_M_FUNC_CFG2;
		end
	end

	// Ratio bytes, lowest address holds the top byte
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ratio
			// Byte slot of this register, 0 at 06h
			localparam integer SLOT = gi;
			always @(posedge core_clk_in) begin
				if (!rst_n_in)
					ratio_q[gi] <= `SCFG_RST_BYTE;
				else if (reg_wr_in && scfg_is_ratio(reg_addr_in) &&
					scfg_ratio_slot(reg_addr_in) == SLOT[1:0])
					ratio_q[gi] <= reg_wdata_in;
			end
			// Byte at address 06h+gi lands in byte gi of the ratio, counted from the top
			assign user_ratio_out[RATIO_W-1-8*gi -: 8] =
				ratio_q[gi]; // see RULE_04
		end
	endgenerate
	// Value is 12.20 unsigned: integer in top 12, fraction in low 20
	// see RULE_05

	// Read mux; unlock bit reflects live loop state
	always @* begin
		rdata_d = `SCFG_RST_BYTE;
		case (reg_addr_in)
			`SCFG_A_DEV_CTRL: begin
				rdata_d = dev_ctrl_q;
				rdata_d[`SCFG_B_UNLOCK] = unlocked; // see RULE_15
			end
			`SCFG_A_DEV_CFG1:  rdata_d = dev_cfg1_q;
			`SCFG_A_GLOB_CFG:  rdata_d = glob_cfg_q;
			`SCFG_A_FUNC_CFG1: rdata_d = func_cfg1_q;
			`SCFG_A_FUNC_CFG2: rdata_d = func_cfg2_q;
			default: begin
				if (scfg_is_ratio(reg_addr_in))
					rdata_d = ratio_q[scfg_ratio_slot(reg_addr_in)];
			end
		endcase
	end

	// Reads answered only in I2C mode
	// SPI reads leave rvalid low and the last read data in place
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out  <= `SCFG_RST_BYTE;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in & ~spi_mode_in; // see RULE_13
			if (reg_rd_in && !spi_mode_in)
				reg_rdata_out <= rdata_d; // see RULE_13
		end
	end

	// Reference divider: rising edges counted per divide ratio
	// Reserved code parks the counter and gives no pulses
	assign ref_rise = timing_reference_in & ~ref_prev_q;

	always @* begin
		div_n       = scfg_div_count(
			func_cfg1_q[`SCFG_F_REF_DIV]); // see RULE_09
		ref_cnt_d   = ref_cnt_q;
		ref_pulse_d = 1'b0;
		if (div_n == `SCFG_DIV_NONE) begin
			ref_cnt_d = `SCFG_DIV_NONE;
		end else if (ref_rise) begin
			if (ref_cnt_q + 3'h1 >= div_n) begin
				ref_cnt_d   = `SCFG_DIV_NONE;
				ref_pulse_d = 1'b1;
			end else begin
				ref_cnt_d = ref_cnt_q + 3'h1;
			end
		end
	end

	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ref_prev_q        <= 1'b0;
			ref_cnt_q         <= `SCFG_DIV_NONE;
			ref_div_pulse_out <= 1'b0;
		end else begin
			ref_prev_q        <= timing_reference_in;
			ref_cnt_q         <= ref_cnt_d;
			ref_div_pulse_out <= ref_pulse_d;
		end
	end

	// Clock output: gated low while unlocked unless told to run
	// Registered so a lock change cannot glitch the pin
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			clk_out_out      <= 1'b0;
			clk_out_oe_n_out <= 1'b1;
		end else begin
			clk_out_out      <= pll_clk_in &
				(pll_locked_in | out_on_unl); // see RULE_11 RULE_12
			clk_out_oe_n_out <= dev_ctrl_app_q[`SCFG_B_CLK_DIS];
		end
	end

	// Auxiliary output source, driver type and polarity
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			aux_out_out      <= 1'b0;
			aux_out_oe_n_out <= 1'b1;
		end else begin
			aux_out_oe_n_out <= dev_ctrl_app_q[`SCFG_B_AUX_DIS];
			case (aux_src)
				`SCFG_AUX_REF:
					aux_out_out <= timing_reference_in;
				`SCFG_AUX_CLK:
					aux_out_out <= pll_clk_in &
						(pll_locked_in | out_on_unl); // see RULE_12
				`SCFG_AUX_LOCK: begin
					// Style bit used only here
					if (lock_style) begin // see RULE_06
						aux_out_out <= 1'b0; // see RULE_08
						aux_out_oe_n_out <= pll_locked_in |
							dev_ctrl_app_q[`SCFG_B_AUX_DIS];
					end else begin
						aux_out_out <= unlocked; // see RULE_07
					end
				end
				// Reserved source code holds the pin low
				default:
					aux_out_out <= 1'b0;
			endcase
		end
	end

endmodule // scfg_top

`default_nettype wire

/* sim/scfg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module scfg_checker #(
	parameter RATIO_W = 32
) (
	// Clock and reset
	input wire               core_clk_in,
	input wire               rst_n_in,
	// Register port
	input wire               reg_wr_in,
	input wire               reg_rd_in,
	input wire [7:0]         reg_addr_in,
	input wire               spi_mode_in,
	input wire [7:0]         reg_rdata_out,
	input wire               reg_rvalid_out,
	// Loop and outputs
	input wire               pll_locked_in,
	input wire               pll_clk_in,
	input wire               ctrl_port_mode_out,
	input wire [RATIO_W-1:0] user_ratio_out,
	input wire               ref_div_pulse_out,
	input wire               clk_out_out,
	input wire               clk_out_oe_n_out
);
	// One domain for all checks
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_read_answered: assert property (reg_rd_in && !spi_mode_in |=> reg_rvalid_out)
		else $error("read not answered");
	a_spi_read_refused: assert property (reg_rd_in && spi_mode_in |=> !reg_rvalid_out)
		else $error("read answered in serial write-only mode");
	a_rdata_hold: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	a_ratio_cause: assert property ($changed(user_ratio_out) |-> $past(reg_wr_in)
		&& $past(reg_addr_in) >= 8'h06 && $past(reg_addr_in) <= 8'h09)
		else $error("ratio changed without a ratio write");
	a_mode_cause: assert property ($rose(ctrl_port_mode_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
		else $error("port mode rose without a write");
	a_clk_locked_run: assert property ($past(rst_n_in) && $past(pll_locked_in) |-> clk_out_out == $past(pll_clk_in))
		else $error("clock output not following loop clock");
	a_clk_oe_release: assert property ($rose(rst_n_in) |=> !clk_out_oe_n_out)
		else $error("clock pin not driven after reset");
	a_unlock_read: assert property (reg_rd_in && !spi_mode_in && reg_addr_in == 8'h02
		|=> reg_rdata_out[7] == !$past(pll_locked_in))
		else $error("unlock status bit wrong");
	a_pulse_single: assert property (ref_div_pulse_out |=> !ref_div_pulse_out)
		else $error("divider pulse longer than one cycle");
	// Main scenarios reached
	c_read: cover property (reg_rvalid_out);
	c_mode: cover property ($rose(ctrl_port_mode_out));
	c_pulse: cover property (ref_div_pulse_out);
endmodule // scfg_checker
bind scfg_top scfg_checker #(.RATIO_W(RATIO_W)) scfg_checker_i (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_addr_in(reg_addr_in), .spi_mode_in(spi_mode_in), .reg_rdata_out(reg_rdata_out),
	.reg_rvalid_out(reg_rvalid_out), .pll_locked_in(pll_locked_in), .pll_clk_in(pll_clk_in),
	.ctrl_port_mode_out(ctrl_port_mode_out), .user_ratio_out(user_ratio_out),
	.ref_div_pulse_out(ref_div_pulse_out), .clk_out_out(clk_out_out),
	.clk_out_oe_n_out(clk_out_oe_n_out));
`default_nettype wire

/* sim/scfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scfg_host (
	// Clock
	input  wire       core_clk_in,
	// Register port
	output reg        reg_wr_out,
	output reg        reg_rd_out,
	output reg  [7:0] reg_addr_out,
	output reg  [7:0] reg_wdata_out,
	output reg        spi_mode_out,
	input  wire [7:0] reg_rdata_in,
	input  wire       reg_rvalid_in
);
	integer i;
	// Idle port at time zero
	initial {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out, spi_mode_out} = 19'h00000;
	// One byte write, strobe for a single edge
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk_in) {reg_wr_out, reg_addr_out, reg_wdata_out} <= {1'b1, a, d};
			@(posedge core_clk_in) reg_wr_out <= 1'b0;
		end
	endtask
	// One read, answer awaited for a bounded time
	task rd(input [7:0] a, input s, output [7:0] d, output ok);
		begin
			ok = 1'b0;
			@(posedge core_clk_in) {reg_rd_out, reg_addr_out, spi_mode_out} <= {1'b1, a, s};
			@(posedge core_clk_in) reg_rd_out <= 1'b0;
			for (i = 0; i < 3 && !ok; i = i + 1) begin
				@(posedge core_clk_in);
				ok = reg_rvalid_in;
			end
			d = reg_rdata_in;
		end
	endtask
endmodule // scfg_host
`default_nettype wire

/* sim/synth_config_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scfg_regs.vh"
module synth_config_registers_bench;
	reg         core_clk = 1'b0, rst_n = 1'b0, locked = 1'b1, pclk = 1'b0, tref = 1'b0;
	wire        wr, rd, spi, rvalid, cpm, rdp, ck, ck_oe_n, ax, ax_oe_n;
	wire [7:0]  addr, wdata, rdata;
	wire [31:0] ratio;
	wire [2:0]  rmod;
	integer     errors = 0, checks = 0, seed = 32'hAD3F0DC9, i, n, k;
	reg  [7:0]  mem [0:24];
	reg  [7:0]  d;
	reg         ok;
	scfg_host scfg_host_i (.core_clk_in(core_clk), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .spi_mode_out(spi),
		.reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
	scfg_top #(.RATIO_W(32)) scfg_top_i (.core_clk_in(core_clk), .rst_n_in(rst_n),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.spi_mode_in(spi), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.pll_locked_in(locked), .pll_clk_in(pclk), .timing_reference_in(tref),
		.ctrl_port_mode_out(cpm), .user_ratio_out(ratio), .rmod_select_out(rmod),
		.ref_div_pulse_out(rdp), .clk_out_out(ck), .clk_out_oe_n_out(ck_oe_n),
		.aux_out_out(ax), .aux_out_oe_n_out(ax_oe_n));
	// Clock, loop clock and reference
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) {pclk, tref} <= {~pclk, ~tref};
	// Compare and count
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("MISMATCH %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// Writable bits per address
	function [7:0] msk(input [7:0] a);
		case (a)
			8'h02: msk = `SCFG_M_DEV_CTRL;
			8'h03: msk = `SCFG_M_DEV_CFG1;
			8'h05: msk = `SCFG_M_GLOB_CFG;
			8'h16: msk = `SCFG_M_FUNC_CFG1;
			8'h17: msk = `SCFG_M_FUNC_CFG2;
			default: msk = (a >= 8'h06 && a <= 8'h09) ? 8'hFF : 8'h00;
		endcase
	endfunction
	// Write and mirror into the model
	task wt(input [7:0] a, input [7:0] x);
		begin
			scfg_host_i.wr(a, x);
			mem[a] = x & msk(a);
		end
	endtask
	// Read and compare with the model
	task rchk(input [7:0] a);
		begin
			scfg_host_i.rd(a, 1'b0, d, ok);
			chk("rvalid", 1, ok);
			chk("rdata", (a == 8'h02) ? {~locked, mem[2][6:0]} : mem[a], d);
		end
	endtask
	// Let a few edges pass, then look between edges
	task nap(input integer c);
		begin
			repeat (c) @(posedge core_clk);
			@(negedge core_clk);
		end
	endtask
	// Final verdict
	task conclude;
		begin
			$display("checks %0d errors %0d", checks, errors);
			if (errors == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		errors = errors + 1;
		conclude;
	end
	// Main sequence
	initial begin
		for (i = 0; i < 25; i = i + 1) mem[i] = 8'h00;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 25; i = i + 1) rchk(i);
		for (i = 0; i < 25; i = i + 1) wt(i, $random(seed) & msk(i));
		for (i = 0; i < 25; i = i + 1) rchk(i);
		chk("ratio", {mem[6], mem[7], mem[8], mem[9]}, ratio);
		@(posedge core_clk) locked <= 1'b0;
		wt(8'h16, 8'hFF);
		rchk(8'h16);
		rchk(8'h02);
		scfg_host_i.rd(8'h02, 1'b1, d, ok);
		chk("spi_read", 0, ok);
		$display("test registers done");
		wt(8'h05, 8'h00);
		wt(8'h02, 8'h00);
		wt(8'h03, 8'h01);
		nap(2);
		chk("port_mode", 0, cpm);
		wt(8'h03, 8'h00);
		wt(8'h05, 8'h09);
		wt(8'h03, 8'hE7);
		wt(8'h02, 8'h01);
		nap(2);
		chk("frozen_rmod", 0, rmod);
		chk("frozen_mode", 0, cpm);
		chk("frozen_clk_oe", 0, ck_oe_n);
		rchk(8'h03);
		wt(8'h05, 8'h01);
		nap(2);
		chk("rmod", 7, rmod);
		chk("port_mode", 1, cpm);
		chk("clk_oe", 1, ck_oe_n);
		wt(8'h02, 8'h00);
		$display("test freeze done");
		for (k = 0; k < 4; k = k + 1) begin
			@(posedge core_clk) locked <= k[1];
			wt(8'h16, k[0] ? 8'h40 : 8'h00);
			nap(3);
			chk("aux", k[0] ? {1'b0, k[1]} : {~k[1], 1'b0}, {ax, ax_oe_n});
		end
		wt(8'h03, 8'h05);
		nap(2);
		chk("aux_clock_oe", 0, ax_oe_n);
		$display("test aux done");
		for (k = 0; k < 2; k = k + 1) begin
			@(posedge core_clk) locked <= 1'b0;
			wt(8'h17, k ? 8'h10 : 8'h00);
			nap(2);
			n = 0;
			for (i = 0; i < 16; i = i + 1) @(posedge core_clk) n = n + ck;
			chk("clk_highs", k ? 8 : 0, n);
		end
		$display("test unlock clock done");
		for (k = 0; k < 4; k = k + 1) begin
			wt(8'h16, k << 3);
			nap(8);
			n = 0;
			for (i = 0; i < 48; i = i + 1) @(posedge core_clk) n = n + rdp;
			chk("ref_pulses", (k == 3) ? 0 : (24 >> (2 - k)), n);
		end
		$display("test divider done");
		wt(8'h06, 8'h00);
		wt(8'h07, 8'h13);
		wt(8'h08, 8'hA9);
		wt(8'h09, 8'h2A);
		nap(1);
		chk("ratio_1p2288", 32'h0013A92A, ratio);
		$display("test ratio done");
		conclude;
	end
endmodule // synth_config_registers_bench
`default_nettype wire
